// ---- core/chri_host_regs.v ----
// What this block does
// R1: A 16-bit index written at 0x00 selects the indirect register reached.
// R2: The index increments after every data-port access.
// R3: Offset 0x04 moves 16 bits to or from the indexed register.
// R4: Offset 0x08 is backed by a 512 by 32 FIFO, direction by mode.
// R5: Host accesses the low half-word before the high half-word; reads pop on the high half, low-half reads see the last popped word.
// R6: Interrupt pin is the OR of masked status flags; register at 0x0C.
// R7: Six status flags set on rising condition edge, cleared on read.
// R8: Service request bit 3 is live, never latched.
// R9: Bit 0 flags an unrecoverable video stream error.
// R10: Bit 1 flags statistics ready; the pin follows the condition.
// R11: Bit 2 and pin flag that the next read returns the last word.
// R12: Bit 4 and pin flag FIFO overflow or underflow, host overflow included.
// R13: Bit 5 and pin flag empty in encode, full less 32 in decode.
// R14: Bit 6 flags memory fault; the fault recovers by itself.
// R15: Enables sit in bits 8 to 14, reset zero; bits 7, 15 read zero.
// R16: Mode bits 3:0 choose format; 0x0 reset, 0x2 multiplexed.
// R17: Bit 4 halves the video clock out; bit 9 selects unipolar chroma.
// R18: Bit 5 selects master timing, sync pins driven by the device.
// R19: Bit 6 selects 625 lines; bit 7 selects encode, set at reset.
// R20: Bit 11 soft reset set at reset; encode ends field, decode stops now.
// R21: Host keeps soft reset set while changing other mode bits.
// R22: Bit 12 inverts sync in blanking; bit 13 makes interrupt active high.
// R23: Service request compares occupancy with 4-bit levels times 32; zero disables.
// R24: A rising condition during a status read keeps the flag set.
`timescale 1ns/1ps
`include "chri_defs.vh"
module chri_host_regs #(
   parameter DEPTH_LOG2 = 9
) (
   // Clock and reset
   input  wire        clk_i,
   input  wire        srst_i,
   // Host bus: byte address, lane enables, strobes
   input  wire [3:0]  addr_i,
   input  wire [3:0]  be_i,
   input  wire        wr_i,
   input  wire        rd_i,
   input  wire [31:0] wdata_i,
   output reg  [31:0] rdata_o,
   output reg         rvalid_o,
   // Codec core stream side
   input  wire        core_push_i,
   input  wire [31:0] core_wdata_i,
   input  wire        core_pop_i,
   output reg  [31:0] core_rdata_o,
   output wire        core_level_ok_o,
   // Codec core events
   input  wire        format_error_i,
   input  wire        stats_ready_i,
   input  wire        last_word_i,
   input  wire        memory_fault_i,
   input  wire        field_done_i,
   // Mode outputs
   output wire [3:0]  video_format_select_o,
   output wire        clock_out_halve_o,
   output wire        timing_master_o,
   output wire        lines_625_o,
   output wire        encode_o,
   output wire        unipolar_chroma_select_o,
   output wire        soft_reset_bit_o,
   output wire        hsync_polarity_o,
   output wire        run_o,
   // Status pins
   output wire        host_interrupt_pin_o,
   output wire        stats_ready_pin_o,
   output wire        last_word_pin_o,
   output wire        service_request_pin_o,
   output wire        queue_error_pin_o,
   output wire        queue_stop_pin_o
);
   localparam DEPTH = 1 << DEPTH_LOG2;

   reg  [15:0] indirect_index;
   reg  [15:0] video_mode_control;
   reg  [15:0] fifo_control;
   reg  [6:0]  irq_enable;
   reg  [DEPTH_LOG2-1:0] wptr;
   reg  [DEPTH_LOG2-1:0] rptr;
   reg  [DEPTH_LOG2:0]   count;
   reg  [15:0] half_low;
   reg  half_pend;
   reg  run;
   reg  queue_err_cond;
   reg  [15:0] ind_rdata;
   reg  mem_re_q;
   reg  mem_re_host_q;
   wire [31:0] mem_rdata;
   wire [6:0]  flags;
   wire [6:0]  conds;

   wire sel_index  = (addr_i == `CHRI_OFS_INDEX);
   wire sel_data   = (addr_i == `CHRI_OFS_DATA);
   wire sel_stream = (addr_i == `CHRI_OFS_STREAM);
   wire sel_irq    = (addr_i == `CHRI_OFS_IRQ);
   wire enc        = video_mode_control[`CHRI_MODE_ENCODE];
   wire soft_reset_bit        = video_mode_control[`CHRI_MODE_SWR];

   assign video_format_select_o    = video_mode_control[`CHRI_MODE_FMT_HI:`CHRI_MODE_FMT_LO]; // [R16]
   assign clock_out_halve_o        = video_mode_control[`CHRI_MODE_HALVE];    // [R17]
   assign unipolar_chroma_select_o = video_mode_control[`CHRI_MODE_UNIPOLAR]; // [R17]
   assign timing_master_o          = video_mode_control[`CHRI_MODE_MASTER];   // [R18]
   assign lines_625_o              = video_mode_control[`CHRI_MODE_625];      // [R19]
   assign encode_o                 = enc;                                     // [R19]
   assign soft_reset_bit_o         = soft_reset_bit;
   assign hsync_polarity_o         = video_mode_control[`CHRI_MODE_HSPOL];    // [R22]
   assign run_o                    = run;

   // Host stream write completes a word on the upper half or a full 32-bit access.
   wire host_wr_stream = wr_i && sel_stream && !enc;
   wire host_word_wr   = host_wr_stream && be_i[3]; // [R5]
   // An upper half without a stored lower half is pushed with a zero lower half.
   wire [31:0] host_word = (be_i[0]) ? wdata_i
                                     : {wdata_i[31:16], half_pend ? half_low : 16'h0000};
   wire host_rd_stream = rd_i && sel_stream && enc;
   wire host_word_rd   = host_rd_stream && (be_i[3] || be_i == 4'hF); // [R5]

   wire full  = (count == DEPTH[DEPTH_LOG2:0]);
   wire empty = (count == {(DEPTH_LOG2+1){1'b0}});

   // Decode: host fills, core drains. Encode: core fills, host drains.
   wire push_req = enc ? core_push_i : host_word_wr; // [R4]
   wire pop_req  = enc ? host_word_rd : core_pop_i;  // [R4]
   wire push     = push_req && !full;
   wire pop      = pop_req && !empty;
   wire [31:0] push_data = enc ? core_wdata_i : host_word;

   chri_fifo_mem #(
      .WIDTH (32),
      .AW    (DEPTH_LOG2)
   ) u_mem (
      .clk_i   (clk_i),
      .we_i    (push),
      .waddr_i (wptr),
      .wdata_i (push_data),
      .re_i    (pop),
      .raddr_i (rptr),
      .rdata_o (mem_rdata)
   );

   always @(posedge clk_i)
   begin
      if (srst_i)
      begin
         wptr      <= {DEPTH_LOG2{1'b0}};
         rptr      <= {DEPTH_LOG2{1'b0}};
         count     <= {(DEPTH_LOG2+1){1'b0}};
         half_low  <= 16'h0000;
         half_pend <= 1'b0;
      end
      else
      begin
         if (push)
         begin
            wptr <= wptr + 1'b1;
         end
         if (pop)
         begin
            rptr <= rptr + 1'b1;
         end
         if (push && !pop)
         begin
            count <= count + 1'b1;
         end
         else if (pop && !push)
         begin
            count <= count - 1'b1;
         end
         if (host_wr_stream && be_i[0] && !be_i[3])
         begin
            half_low  <= wdata_i[15:0];
            half_pend <= 1'b1;
         end
         else if (host_word_wr)
         begin
            half_pend <= 1'b0;
         end
      end
   end

   // Overflow or underflow on either side, host or core.
   always @*
   begin
      if (enc)
      begin
         queue_err_cond = (core_push_i && full) || (host_word_rd && empty); // [R12]
      end
      else
      begin
         queue_err_cond = (host_word_wr && full) || (core_pop_i && empty); // [R12]
      end
   end

   wire stop_cond = enc ? empty
                        : (count >= DEPTH[DEPTH_LOG2:0] - `CHRI_STOP_MARGIN); // [R13]
   wire [3:0] encode_service_level = fifo_control[3:0];
   wire [3:0] decode_service_level = fifo_control[7:4];
   wire [DEPTH_LOG2:0] free = DEPTH[DEPTH_LOG2:0] - count;
   // In decode a higher level asks for service with fewer free entries.
   wire srq = enc ? ((encode_service_level != 4'h0) && (count >= encode_service_level * `CHRI_LEVEL_STEP))
                  : ((decode_service_level != 4'h0) && (free >= (5'h10 - decode_service_level) * `CHRI_LEVEL_STEP)); // [R23]
   assign core_level_ok_o = enc ? !full : !empty;

   assign conds = {memory_fault_i, stop_cond, queue_err_cond, 1'b0,
                   last_word_i, stats_ready_i, format_error_i};
   wire irq_read = rd_i && sel_irq;

   genvar g;
   generate
      for (g = 0; g < `CHRI_IRQ_NFLAGS; g = g + 1)
      begin : g_flag
         if (g == `CHRI_FLAG_SRQ)
         begin : g_live
            assign flags[g] = srq; // [R8]
         end
         else
         begin : g_sticky
            chri_edge_flag u_flag (
               .clk_i  (clk_i),
               .srst_i (srst_i),
               .cond_i (conds[g]),
               .clr_i  (irq_read),
               .flag_o (flags[g])
            ); // [R9] [R10] [R11] [R12] [R13] [R14]
         end
      end
   endgenerate

   // Memory fault recovery is left to the core; no host action is needed.
   assign stats_ready_pin_o     = stats_ready_i;  // [R10]
   assign last_word_pin_o       = last_word_i;    // [R11]
   assign service_request_pin_o = srq;
   assign queue_error_pin_o     = queue_err_cond; // [R12]
   assign queue_stop_pin_o      = stop_cond;      // [R13]

   wire irq_any = |(flags & irq_enable); // [R6]
   assign host_interrupt_pin_o = video_mode_control[`CHRI_MODE_IRQPOL] ? irq_any : !irq_any; // [R22]

   wire data_access = sel_data && (wr_i || rd_i);

   // Register writes and index stepping.
   always @(posedge clk_i)
   begin
      if (srst_i)
      begin
         indirect_index     <= 16'h0000;
         video_mode_control <= `CHRI_MODE_RESET; // [R20]
         fifo_control       <= `CHRI_FCTL_RESET;
         irq_enable         <= 7'h00; // [R15]
      end
      else
      begin
         if (wr_i && sel_index)
         begin
            indirect_index <= wdata_i[15:0]; // [R1]
         end
         else if (data_access)
         begin
            indirect_index <= indirect_index + 16'h0001; // [R2]
         end
         if (wr_i && sel_data)
         begin
            if (indirect_index == `CHRI_IDX_MODE)
            begin
               video_mode_control <= wdata_i[15:0] & `CHRI_MODE_WMASK; // [R3] [R21]
            end
            if (indirect_index == `CHRI_IDX_FIFOCTL)
            begin
               fifo_control <= wdata_i[15:0] & `CHRI_FCTL_WMASK; // [R3]
            end
         end
         if (wr_i && sel_irq)
         begin
            irq_enable <= wdata_i[14:8]; // [R15]
         end
      end
   end

   // Processing gate: encode stops at field end, decode stops at once.
   always @(posedge clk_i)
   begin
      if (srst_i)
      begin
         run <= 1'b0;
      end
      else if (!soft_reset_bit)
      begin
         run <= 1'b1;
      end
      else if (!enc || field_done_i)
      begin
         run <= 1'b0; // [R20]
      end
   end

   always @*
   begin
      case (indirect_index)
         `CHRI_IDX_MODE:    ind_rdata = video_mode_control;
         `CHRI_IDX_FIFOCTL: ind_rdata = fifo_control;
         default:           ind_rdata = 16'h0000;
      endcase
   end

   // Read data register; stream reads arrive one cycle after the memory read.
   always @(posedge clk_i)
   begin
      if (srst_i)
      begin
         rdata_o       <= 32'h00000000;
         rvalid_o      <= 1'b0;
         mem_re_q      <= 1'b0;
         mem_re_host_q <= 1'b0;
         core_rdata_o  <= 32'h00000000;
      end
      else
      begin
         mem_re_q      <= pop;
         mem_re_host_q <= pop && enc;
         rvalid_o      <= 1'b0;
         if (mem_re_q && !mem_re_host_q)
         begin
            core_rdata_o <= mem_rdata;
         end
         if (mem_re_host_q)
         begin
            rdata_o  <= mem_rdata;
            rvalid_o <= 1'b1;
         end
         else if (host_rd_stream && !host_word_rd)
         begin
            rdata_o  <= {16'h0000, mem_rdata[15:0]};
            rvalid_o <= 1'b1;
         end
         else if (rd_i && !sel_stream)
         begin
            rvalid_o <= 1'b1;
            if (sel_data)
            begin
               rdata_o <= {16'h0000, ind_rdata}; // [R3]
            end
            else if (sel_irq)
            begin
               rdata_o <= {16'h0000, 1'b0, irq_enable, 1'b0, flags}; // [R15]
            end
            else
            begin
               rdata_o <= 32'h00000000;
            end
         end
         // A word read that pops memory is answered a cycle later, never here.
         else if (rd_i && !(host_word_rd && !empty))
         begin
            rvalid_o <= 1'b1;
            rdata_o  <= 32'h00000000;
         end
      end
   end
endmodule // chri_host_regs

// ---- core/chri_defs.vh ----
`ifndef CHRI_DEFS_VH
`define CHRI_DEFS_VH
// Direct register byte offsets.
`define CHRI_OFS_INDEX      4'h0
`define CHRI_OFS_DATA       4'h4
`define CHRI_OFS_STREAM     4'h8
`define CHRI_OFS_IRQ        4'hC
// Indirect register indices.
`define CHRI_IDX_MODE       16'h0000
`define CHRI_IDX_FIFOCTL    16'h0001
// Mode control fields and reset value.
`define CHRI_MODE_FMT_LO    0
`define CHRI_MODE_FMT_HI    3
`define CHRI_MODE_HALVE     4
`define CHRI_MODE_MASTER    5
`define CHRI_MODE_625       6
`define CHRI_MODE_ENCODE    7
`define CHRI_MODE_UNIPOLAR  9
`define CHRI_MODE_SWR       11
`define CHRI_MODE_HSPOL     12
`define CHRI_MODE_IRQPOL    13
`define CHRI_MODE_WMASK     16'hFAFF
`define CHRI_MODE_RESET     16'h0880
`define CHRI_FMT_656        4'h0
`define CHRI_FMT_MUX        4'h2
// FIFO control fields and reset value.
`define CHRI_FCTL_RESET     16'h0088
`define CHRI_FCTL_WMASK     16'h00FF
// Interrupt register layout.
`define CHRI_IRQ_NFLAGS     7
`define CHRI_IRQ_MASK_LO    8
`define CHRI_FLAG_SRQ       3
`define CHRI_STICKY_MASK    7'h77
// Service-level step and stop margin in FIFO entries.
`define CHRI_LEVEL_STEP     32
`define CHRI_STOP_MARGIN    32
`endif

// ---- core/chri_fifo_mem.v ----
`timescale 1ns/1ps
// Simple dual-port memory with registered read data.
module chri_fifo_mem #(
   parameter WIDTH = 32,
   parameter AW    = 9
) (
   // Clock
   input  wire             clk_i,
   // Write port
   input  wire             we_i,
   input  wire [AW-1:0]    waddr_i,
   input  wire [WIDTH-1:0] wdata_i,
   // Read port
   input  wire             re_i,
   input  wire [AW-1:0]    raddr_i,
   output reg  [WIDTH-1:0] rdata_o
);
   reg [WIDTH-1:0] mem [0:(1<<AW)-1];

   always @(posedge clk_i)
   begin
      if (we_i)
      begin
         mem[waddr_i] <= wdata_i;
      end
      if (re_i)
      begin
         rdata_o <= mem[raddr_i];
      end
   end
endmodule // chri_fifo_mem

// ---- core/chri_edge_flag.v ----
`timescale 1ns/1ps
// Sticky flag set on the rising edge of a condition, cleared by a read.
module chri_edge_flag (
   // Clock and reset
   input  wire clk_i,
   input  wire srst_i,
   // Condition and clear
   input  wire cond_i,
   input  wire clr_i,
   // Flag
   output reg  flag_o
);
   reg cond_q;

   always @(posedge clk_i)
   begin
      if (srst_i)
      begin
         cond_q <= 1'b0;
         flag_o <= 1'b0;
      end
      else
      begin
         cond_q <= cond_i;
         // A rising edge in the clearing cycle keeps the flag set.
         if (cond_i && !cond_q)
         begin
            flag_o <= 1'b1; // [R7] [R24]
         end
         else if (clr_i)
         begin
            flag_o <= 1'b0; // [R7]
         end
      end
   end
endmodule // chri_edge_flag

// ---- verif/chri_host_regs_asserts.sv ----
`timescale 1ns/1ps
module chri_host_regs_asserts (
   // Clock and reset
   input wire       clk_i,
   input wire       srst_i,
   // Host and core inputs
   input wire [3:0] addr_i,
   input wire       rd_i,
   input wire       core_push_i,
   input wire       field_done_i,
   input wire       stats_ready_i,
   input wire       last_word_i,
   // Observed outputs
   input wire       rvalid_o,
   input wire       core_level_ok_o,
   input wire       encode_o,
   input wire       soft_reset_bit_o,
   input wire       run_o,
   input wire       stats_ready_pin_o,
   input wire       last_word_pin_o,
   input wire       queue_stop_pin_o,
   input wire       queue_error_pin_o,
   input wire       host_interrupt_pin_o,
   input wire [3:0] video_format_select_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (srst_i);

   rd_answer_a: assert property (rd_i && addr_i != 4'h8 |=> rvalid_o)
      else $error("register read gave no answer");
   no_stray_a: assert property (rvalid_o |-> $past(rd_i) || $past(rd_i, 2))
      else $error("answer without a read");
   mode_reset_a: assert property ($past(srst_i) |-> encode_o && soft_reset_bit_o
      && !run_o && video_format_select_o == 4'h0)
      else $error("mode outputs wrong after reset");
   irq_idle_a: assert property ($past(srst_i) |-> host_interrupt_pin_o)
      else $error("interrupt pin not idle high after reset");
   stats_pin_a: assert property (stats_ready_pin_o == stats_ready_i)
      else $error("statistics pin does not follow condition");
   last_pin_a: assert property (last_word_pin_o == last_word_i)
      else $error("last word pin does not follow condition");
   push_full_a: assert property (encode_o && core_push_i && !core_level_ok_o
      |-> ##[0:1] queue_error_pin_o)
      else $error("overflow in encode gave no error");
   swr_decode_a: assert property (!encode_o && soft_reset_bit_o |=> !run_o)
      else $error("decode kept running under soft reset");
   swr_encode_a: assert property (encode_o && run_o && soft_reset_bit_o
      && !field_done_i |=> run_o)
      else $error("encode stopped before the field ended");
   stop_cleared_a: assert property (encode_o && queue_stop_pin_o && core_push_i
      |=> !queue_stop_pin_o)
      else $error("stop stayed high after a push in encode");

   cover property (encode_o && core_push_i && !core_level_ok_o);
   cover property (!encode_o && run_o && host_interrupt_pin_o);
   cover property (encode_o && soft_reset_bit_o && field_done_i);
endmodule // chri_host_regs_asserts

bind chri_host_regs chri_host_regs_asserts u_chk (
   .clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i), .rd_i(rd_i),
   .core_push_i(core_push_i), .field_done_i(field_done_i),
   .stats_ready_i(stats_ready_i), .last_word_i(last_word_i), .rvalid_o(rvalid_o),
   .core_level_ok_o(core_level_ok_o), .encode_o(encode_o),
   .soft_reset_bit_o(soft_reset_bit_o), .run_o(run_o),
   .stats_ready_pin_o(stats_ready_pin_o), .last_word_pin_o(last_word_pin_o),
   .queue_stop_pin_o(queue_stop_pin_o), .queue_error_pin_o(queue_error_pin_o),
   .host_interrupt_pin_o(host_interrupt_pin_o),
   .video_format_select_o(video_format_select_o));

// ---- verif/chri_host_model.sv ----
`timescale 1ns/1ps
module chri_host_model (
   // Clock
   input  wire        clk_i,
   // Answer from the device
   input  wire        rvalid_i,
   input  wire [31:0] rdata_i,
   // Bus requests
   output reg  [3:0]  addr_o,
   output reg  [3:0]  be_o,
   output reg         wr_o,
   output reg         rd_o,
   output reg  [31:0] wdata_o
);
   initial
   begin
      addr_o = 4'h0;
      be_o = 4'h0;
      wr_o = 1'b0;
      rd_o = 1'b0;
      wdata_o = 32'h0;
   end
   // Released write data shows its inverse so stale values cannot pass.
   task put(input [3:0] a, input [3:0] b, input [31:0] d);
      begin
         @(posedge clk_i);
         addr_o <= a;
         be_o <= b;
         wdata_o <= d;
         wr_o <= 1'b1;
         @(posedge clk_i);
         wr_o <= 1'b0;
         wdata_o <= ~d;
      end
   endtask
   task get(input [3:0] a, input [3:0] b, output [31:0] d, output ok);
      integer k;
      begin
         ok = 1'b0;
         d = 32'h0;
         @(posedge clk_i);
         addr_o <= a;
         be_o <= b;
         rd_o <= 1'b1;
         @(posedge clk_i);
         rd_o <= 1'b0;
         for (k = 0; k < 4 && !ok; k = k + 1)
         begin
            @(posedge clk_i);
            if (rvalid_i === 1'b1)
            begin
               ok = 1'b1;
               d = rdata_i;
            end
         end
      end
   endtask
   task put16(input [31:0] d);
      begin
         put(4'h8, 4'h3, d);
         put(4'h8, 4'hC, d);
      end
   endtask
   // Callers pass values with the soft reset bit set when other bits change.
   task set_mode(input [15:0] v);
      begin
         put(4'h0, 4'hF, 32'h0);
         put(4'h4, 4'hF, {16'h0, v});
      end
   endtask
endmodule // chri_host_model

// ---- verif/test_chri_host_regs.sv ----
`timescale 1ns/1ps
module test_chri_host_regs;
   typedef struct packed {
      logic        w;
      logic [3:0]  a;
      logic [31:0] d;
      logic [15:0] m;
      logic [15:0] e;
   } chri_row_t;
   localparam chri_row_t rows [0:16] = '{
      '{1'b1, 4'h0, 32'h1, 16'h0, 16'h0}, '{1'b0, 4'h4, 32'h0, 16'hFFFF, 16'h0088},
      '{1'b1, 4'h0, 32'h1, 16'h0, 16'h0}, '{1'b1, 4'h4, 32'h1, 16'h0, 16'h0},
      '{1'b1, 4'h0, 32'h0, 16'h0, 16'h0}, '{1'b0, 4'h4, 32'h0, 16'hFFFF, 16'h0880},
      '{1'b0, 4'h4, 32'h0, 16'hFFFF, 16'h0001}, '{1'b0, 4'h4, 32'h0, 16'hFFFF, 16'h0000},
      '{1'b0, 4'hC, 32'h0, 16'hFF80, 16'h0000}, '{1'b1, 4'hC, 32'hFFFFFFFF, 16'h0, 16'h0},
      '{1'b0, 4'hC, 32'h0, 16'hFF80, 16'h7F00}, '{1'b1, 4'h0, 32'h0, 16'h0, 16'h0},
      '{1'b1, 4'h4, 32'h2880, 16'h0, 16'h0}, '{1'b1, 4'h0, 32'h0, 16'h0, 16'h0},
      '{1'b1, 4'h4, 32'h2080, 16'h0, 16'h0}, '{1'b1, 4'h0, 32'h0, 16'h0, 16'h0},
      '{1'b0, 4'h4, 32'h0, 16'hFFFF, 16'h2080}};
   reg         clk_i = 1'b0;
   reg         srst_i = 1'b1;
   reg         core_push_i = 1'b0;
   reg  [31:0] core_wdata_i = 32'h0;
   reg         core_pop_i = 1'b0;
   reg  [3:0]  ev = 4'h0;
   reg         field_done_i = 1'b0;
   wire [3:0]  addr;
   wire [3:0]  be;
   wire        wr;
   wire        rd;
   wire [31:0] wdata;
   wire [31:0] rdata;
   wire        rvalid;
   wire [31:0] core_rdata_o;
   wire [3:0]  video_format_select_o;
   wire        core_level_ok_o, clock_out_halve_o, timing_master_o, lines_625_o, encode_o;
   wire        unipolar_chroma_select_o, soft_reset_bit_o, hsync_polarity_o, run_o;
   wire        host_interrupt_pin_o, service_request_pin_o, queue_stop_pin_o;
   integer     n_errors = 0;
   integer     tests_run = 0;
   integer     np = 0;
   integer     i;
   integer     b;
   reg  [31:0] d;

   always #4 clk_i = ~clk_i;

   chri_host_model u_chri_host_model (.clk_i(clk_i), .rvalid_i(rvalid), .rdata_i(rdata),
      .addr_o(addr), .be_o(be), .wr_o(wr), .rd_o(rd), .wdata_o(wdata));
   chri_host_regs u_chri_host_regs (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr),
      .be_i(be), .wr_i(wr), .rd_i(rd), .wdata_i(wdata), .rdata_o(rdata), .rvalid_o(rvalid),
      .core_push_i(core_push_i), .core_wdata_i(core_wdata_i), .core_pop_i(core_pop_i),
      .core_rdata_o(core_rdata_o), .core_level_ok_o(core_level_ok_o),
      .format_error_i(ev[0]), .stats_ready_i(ev[1]), .last_word_i(ev[2]),
      .memory_fault_i(ev[3]), .field_done_i(field_done_i),
      .video_format_select_o(video_format_select_o), .clock_out_halve_o(clock_out_halve_o),
      .timing_master_o(timing_master_o), .lines_625_o(lines_625_o), .encode_o(encode_o),
      .unipolar_chroma_select_o(unipolar_chroma_select_o),
      .soft_reset_bit_o(soft_reset_bit_o), .hsync_polarity_o(hsync_polarity_o),
      .run_o(run_o), .host_interrupt_pin_o(host_interrupt_pin_o), .stats_ready_pin_o(),
      .last_word_pin_o(), .service_request_pin_o(service_request_pin_o),
      .queue_error_pin_o(), .queue_stop_pin_o(queue_stop_pin_o));

   task complete_run;
      begin
         $display("checks %0d errors %0d", tests_run, n_errors);
         if (n_errors == 0 && tests_run > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask
   task chk(input [31:0] g, input [31:0] e);
      begin
         tests_run = tests_run + 1;
         if (g !== e)
         begin
            n_errors = n_errors + 1;
            $display("[FAIL] %0t got %h want %h", $time, g, e);
         end
      end
   endtask
   task rdw(input [3:0] a, output [31:0] v);
      reg ok;
      begin
         u_chri_host_model.get(a, 4'hF, v, ok);
         if (!ok)
         begin
            n_errors = n_errors + 1;
            $display("[FAIL] %0t read timed out", $time);
            complete_run;
         end
      end
   endtask
   task rdc(input [3:0] a, input [15:0] m, input [15:0] e);
      begin
         rdw(a, d);
         chk({16'h0, d[15:0] & m}, {16'h0, e});
      end
   endtask
   task cpush(input integer n);
      integer k;
      begin
         for (k = 0; k < n; k = k + 1)
         begin
            @(posedge clk_i);
            core_push_i <= 1'b1;
            core_wdata_i <= 32'hA000_0000 + np;
            np = np + 1;
         end
         @(posedge clk_i);
         core_push_i <= 1'b0;
         #1;
      end
   endtask
   task cpop;
      begin
         @(posedge clk_i);
         core_pop_i <= 1'b1;
         @(posedge clk_i);
         core_pop_i <= 1'b0;
         repeat (2) @(posedge clk_i);
         #1;
      end
   endtask

   initial
   begin
      repeat (8) @(posedge clk_i);
      srst_i <= 1'b0;
      for (i = 0; i < 17; i = i + 1)
         if (rows[i].w)
            u_chri_host_model.put(rows[i].a, 4'hF, rows[i].d);
         else
            rdc(rows[i].a, rows[i].m, rows[i].e);
      $display("register rows done");
      #1;
      chk(queue_stop_pin_o, 1);
      cpush(31);
      chk(service_request_pin_o, 0);
      cpush(1);
      chk(service_request_pin_o, 1);
      rdc(4'hC, 16'h0008, 16'h0008);
      rdc(4'hC, 16'h0008, 16'h0008);
      for (i = 0; i < 32; i = i + 1)
      begin
         rdw(4'h8, d);
         chk(d, 32'hA000_0000 + i);
      end
      #1;
      chk(queue_stop_pin_o, 1);
      cpush(513);
      rdc(4'hC, 16'h0010, 16'h0010);
      for (i = 0; i < 512; i = i + 1)
         rdw(4'h8, d);
      chk(d, 32'hA000_021F);
      u_chri_host_model.set_mode(16'h2880);
      repeat (3) @(posedge clk_i);
      #1;
      chk(run_o, 1);
      @(posedge clk_i);
      field_done_i <= 1'b1;
      @(posedge clk_i);
      field_done_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      #1;
      chk(run_o, 0);
      $display("encode done");
      u_chri_host_model.set_mode(16'h3F72);
      u_chri_host_model.set_mode(16'h3672);
      u_chri_host_model.put(4'h0, 4'hF, 32'h0);
      rdc(4'h4, 16'hFFFF, 16'h3272);
      chk({video_format_select_o, clock_out_halve_o, timing_master_o, lines_625_o, encode_o,
         unipolar_chroma_select_o, soft_reset_bit_o, hsync_polarity_o, run_o},
         12'h2EB);
      rdc(4'hC, 16'h0000, 16'h0000);
      chk(host_interrupt_pin_o, 0);
      for (i = 0; i < 4; i = i + 1)
      begin
         b = (i == 3) ? 6 : i;
         @(posedge clk_i);
         ev[i] <= 1'b1;
         repeat (2) @(posedge clk_i);
         #1;
         chk(host_interrupt_pin_o, 1);
         rdc(4'hC, 16'h0001 << b, 16'h0001 << b);
         rdc(4'hC, 16'h0001 << b, 16'h0000);
         ev[i] <= 1'b0;
      end
      fork
         rdw(4'hC, d);
         begin
            @(posedge clk_i);
            ev[0] <= 1'b1;
         end
      join
      u_chri_host_model.put(4'hC, 4'hF, 32'h0);
      #1;
      chk(host_interrupt_pin_o, 0);
      rdc(4'hC, 16'h0001, 16'h0001);
      ev[0] <= 1'b0;
      u_chri_host_model.put16(32'h1234_5678);
      u_chri_host_model.put(4'h8, 4'hF, 32'hCAFE_0001);
      cpop;
      chk(core_rdata_o, 32'h1234_5678);
      cpop;
      chk(core_rdata_o, 32'hCAFE_0001);
      chk(core_level_ok_o, 0);
      cpop;
      rdc(4'hC, 16'h0010, 16'h0010);
      for (i = 1; i < 514; i = i + 1)
      begin
         u_chri_host_model.put(4'h8, 4'hF, i);
         #1;
         if (i == 479 || i == 480)
            chk(queue_stop_pin_o, i == 480);
      end
      rdc(4'hC, 16'h0030, 16'h0030);
      u_chri_host_model.set_mode(16'h3A72);
      @(posedge clk_i);
      #1;
      chk(run_o, 0);
      $display("decode done");
      complete_run;
   end
endmodule // test_chri_host_regs
